// ### rtl/wwd_pkg.sv
// shared constants, register map and state encoding of the window watchdog
package wwd_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ          = 50_000_000;
  localparam int TICK_US         = 1000;
  localparam int TICK_CYCLES     = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int MS_W            = 16;

  // preset bounds and delays in milliseconds
  localparam logic [15:0] UPPER_PULLUP_MS = 16'h0064;
  localparam logic [15:0] UPPER_OPEN_MS   = 16'h03e8;
  localparam logic [15:0] DELAY_PULLUP_MS = 16'h000a;
  localparam logic [15:0] DELAY_OPEN_MS   = 16'h00c8;

  // ----------------------------------------------------------------------
  // configuration pin states and select codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] CFG_CAP     = 2'h0;
  localparam logic [1:0] CFG_PULLUP  = 2'h1;
  localparam logic [1:0] CFG_OPEN    = 2'h2;
  localparam logic [1:0] SEL_RATIO8  = 2'h0;
  localparam logic [1:0] SEL_OFF     = 2'h1;
  localparam logic [1:0] SEL_RATIO2  = 2'h2;
  localparam logic [1:0] SEL_RATIO4  = 2'h3;
  localparam int         SHIFT_R8    = 3;
  localparam int         SHIFT_R2    = 1;
  localparam int         SHIFT_R4    = 2;

  // ----------------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS    = 8'h00;
  localparam logic [7:0] OFS_MASK      = 8'h04;
  localparam logic [7:0] OFS_STATE     = 8'h08;
  localparam logic [7:0] OFS_CAP_UPPER = 8'h0c;
  localparam logic [7:0] OFS_CAP_DELAY = 8'h10;
  localparam logic [7:0] OFS_COUNT     = 8'h14;

  // event bits of status and mask
  localparam int EV_TIMEOUT  = 0;
  localparam int EV_EARLY    = 1;
  localparam int EV_RELEASE  = 2;
  localparam int EV_GOOD     = 3;
  localparam int EV_N        = 4;

  // fields of the state register
  localparam int ST_FAULT_BIT = 0;
  localparam int ST_OFF_BIT   = 1;
  localparam int ST_PIN_BIT   = 2;
  localparam int ST_FSM_LSB   = 8;

  localparam logic [3:0]  MASK_RST      = 4'h0;
  localparam logic [15:0] CAP_UPPER_RST = 16'h01f4;
  localparam logic [15:0] CAP_DELAY_RST = 16'h0032;

  // ----------------------------------------------------------------------
  // watchdog states
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_INIT   = 5'h01,
    ST_CLOSED = 5'h02,
    ST_WINDOW = 5'h04,
    ST_FAULT  = 5'h08,
    ST_OFF    = 5'h10
  } wwd_state_t;

endpackage

// ### rtl/wwd_tick.sv
// millisecond tick divider with restart
`timescale 1ns/10ps
module wwd_tick #(
  parameter int CYCLES = 50000
) (
  input  wire logic CLK,
  input  wire logic NRST,
  input  wire logic CLEAR,
  output logic      TICK
);
  import wwd_pkg::*;

  localparam int W = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } wwd_tick_regs_t;

  localparam wwd_tick_regs_t RST_VAL = '0;

  wwd_tick_regs_t s;
  wwd_tick_regs_t next_s;

  // clear realigns the phase so every interval starts at a full tick
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (CLEAR) begin
      next_s.cnt = '0;
    end else if (s.cnt == W'(CYCLES - 1)) begin
      next_s.cnt  = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + W'(1);
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      s <= RST_VAL;
    end else begin
      s <= next_s;
    end
  end

  assign TICK = s.tick;

endmodule

// ### rtl/wwd_top.sv
// window watchdog core with ahb-lite register slave
//
// What this block does
// - kicks are ignored during the power-up reset delay.
// - kicks are ignored while the fault output is asserted.
// - kicks are ignored while the watchdog is disabled by the select inputs.
// - a timeout pulls the fault output low for the reset delay, then releases it.
// - while disabled the fault output stays released whatever the kick does.
// - the fault output is open drain, active low, it only ever pulls low.
// - both select bits and the timeout pin state pick ratio, timeout or disable.
// - timeout pin pulled up or open picks a preset upper bound, capacitor sets it.
// - the lower bound follows the select bits, also in capacitor mode.
// - delay pin pulled up or open picks a preset delay, capacitor programs it.
//
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
module wwd_top
  import wwd_pkg::*;
#(
  parameter int          TICK_N     = wwd_pkg::TICK_CYCLES,
  parameter logic [15:0] UP_PU_MS   = wwd_pkg::UPPER_PULLUP_MS,
  parameter logic [15:0] UP_NC_MS   = wwd_pkg::UPPER_OPEN_MS,
  parameter logic [15:0] DLY_PU_MS  = wwd_pkg::DELAY_PULLUP_MS,
  parameter logic [15:0] DLY_NC_MS  = wwd_pkg::DELAY_OPEN_MS
) (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        KICK_INPUT,
  input  wire logic        WINDOW_SELECT_BIT0,
  input  wire logic        WINDOW_SELECT_BIT1,
  input  wire logic [1:0]  TIMEOUT_CONFIG_PIN,
  input  wire logic [1:0]  DELAY_CONFIG_PIN,
  input  wire logic        FAULT_RESET_OUTPUT_I,
  output logic             FAULT_RESET_OUTPUT_O,
  output logic             FAULT_RESET_OUTPUT_OE_N,
  output logic             IRQ,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic [31:0]      HRDATA,
  output logic             HRESP
);
  import wwd_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    wwd_state_t        fsm;
    logic [MS_W-1:0]   cnt;
    logic              kick_prev;
    logic [EV_N-1:0]   status;
    logic [EV_N-1:0]   mask;
    logic [15:0]       cap_upper;
    logic [15:0]       cap_delay;
    logic [31:0]       rdata;
    logic              wr_pend;
    logic [7:0]        wr_addr;
  } wwd_regs_t;

  localparam wwd_regs_t RST_VAL = '{
    fsm:       ST_INIT,
    cnt:       '0,
    kick_prev: 1'b0,
    status:    '0,
    mask:      MASK_RST,
    cap_upper: CAP_UPPER_RST,
    cap_delay: CAP_DELAY_RST,
    rdata:     '0,
    wr_pend:   1'b0,
    wr_addr:   '0
  };

  wwd_regs_t       s;
  wwd_regs_t       next_s;
  logic            tick;
  logic            tick_clr;
  logic            restart;
  logic [1:0]      sel;
  logic            dis;
  logic            fall;
  logic [15:0]     upper_ms;
  logic [15:0]     lower_ms;
  logic [15:0]     delay_ms;
  logic            addr_ph;
  logic [EV_N-1:0] ev;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // pulled-up preset for pull-up, capacitor value for capacitor, open preset for any other code
  function automatic logic [15:0] pick_ms(input logic [1:0]  cfg,
                                          input logic [15:0] pu,
                                          input logic [15:0] nc,
                                          input logic [15:0] cap);
    logic [15:0] v;
    v = cap;
    if (cfg == CFG_PULLUP) begin
      v = pu;
    end else if (cfg != CFG_CAP) begin
      v = nc;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------------
  assign sel      = {WINDOW_SELECT_BIT1, WINDOW_SELECT_BIT0};
  assign dis      = (sel == SEL_OFF);
  assign upper_ms = pick_ms(TIMEOUT_CONFIG_PIN, UP_PU_MS, UP_NC_MS,
                            s.cap_upper);
  assign delay_ms = pick_ms(DELAY_CONFIG_PIN, DLY_PU_MS, DLY_NC_MS,
                            s.cap_delay);

  // lower bound is a select-chosen fraction of whatever upper is in use
  always_comb begin
    case (sel)
      SEL_RATIO2: lower_ms = upper_ms >> SHIFT_R2;
      SEL_RATIO4: lower_ms = upper_ms >> SHIFT_R4;
      default:    lower_ms = upper_ms >> SHIFT_R8;
    endcase
  end

  // inputs are synchronous to CLK, so one stage gives the edge
  assign fall    = s.kick_prev & ~KICK_INPUT;
  assign addr_ph = HSEL & HREADY & HTRANS[1];

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    ev     = '0;
    next_s.kick_prev = KICK_INPUT;
    if (tick && (s.cnt != {MS_W{1'b1}})) begin
      next_s.cnt = s.cnt + 16'h0001;
    end

    case (s.fsm)
      ST_INIT: begin
        // power-up delay: kicks have no path out of here
        if (dis) begin
          next_s.fsm = ST_OFF;
        end else if (s.cnt >= delay_ms) begin
          next_s.fsm = ST_CLOSED;
        end
      end
      ST_CLOSED: begin
        if (dis) begin
          next_s.fsm = ST_OFF;
        end else if (fall) begin
          next_s.fsm     = ST_FAULT;
          ev[EV_EARLY]   = 1'b1;
        end else if (s.cnt >= lower_ms) begin
          next_s.fsm = ST_WINDOW;
        end
      end
      ST_WINDOW: begin
        if (dis) begin
          next_s.fsm = ST_OFF;
        end else if (fall) begin
          next_s.fsm   = ST_CLOSED;
          ev[EV_GOOD]  = 1'b1;
        end else if (s.cnt >= upper_ms) begin
          next_s.fsm     = ST_FAULT;
          ev[EV_TIMEOUT] = 1'b1;
        end
      end
      ST_FAULT: begin
        // kicks are not looked at while the output is low
        if (dis) begin
          next_s.fsm = ST_OFF;
        end else if (s.cnt >= delay_ms) begin
          next_s.fsm     = ST_CLOSED;
          ev[EV_RELEASE] = 1'b1;
        end
      end
      ST_OFF: begin
        if (!dis) begin
          next_s.fsm = ST_CLOSED;
        end
      end
      default: begin
        next_s.fsm = ST_INIT;
      end
    endcase

    // every interval is timed from zero, but the window keeps the period
    // count: both bounds are measured from the same start of the period
    restart = (next_s.fsm != s.fsm) &&
              !((s.fsm == ST_CLOSED) && (next_s.fsm == ST_WINDOW));
    if (restart) begin
      next_s.cnt = '0;
    end

    // ---------------- register slave ----------------
    if (s.wr_pend) begin
      case (s.wr_addr)
        OFS_MASK:      next_s.mask      = HWDATA[EV_N-1:0];
        OFS_CAP_UPPER: next_s.cap_upper = HWDATA[15:0];
        OFS_CAP_DELAY: next_s.cap_delay = HWDATA[15:0];
        default:       next_s.wr_pend   = 1'b0;
      endcase
    end
    next_s.wr_pend = addr_ph & HWRITE;
    next_s.wr_addr = HADDR[7:0];

    // read data is latched at the address phase so it comes from a flop
    if (addr_ph && !HWRITE) begin
      case (HADDR[7:0])
        OFS_STATUS:    next_s.rdata = {28'h0000000, s.status};
        OFS_MASK:      next_s.rdata = {28'h0000000, s.mask};
        OFS_STATE:     next_s.rdata = {19'h00000, s.fsm, 5'h00, FAULT_RESET_OUTPUT_I,
                                       dis, (s.fsm == ST_FAULT)};
        OFS_CAP_UPPER: next_s.rdata = {16'h0000, s.cap_upper};
        OFS_CAP_DELAY: next_s.rdata = {16'h0000, s.cap_delay};
        OFS_COUNT:     next_s.rdata = {16'h0000, s.cnt};
        default:       next_s.rdata = 32'h00000000;
      endcase
    end

    // read clears status, a same-cycle event still lands
    if (addr_ph && !HWRITE && (HADDR[7:0] == OFS_STATUS)) begin
      next_s.status = ev;
    end else begin
      next_s.status = s.status | ev;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      s <= RST_VAL;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // tick divider
  // ----------------------------------------------------------------------
  // tick phase follows the count, so it restarts together with it
  assign tick_clr = restart;

  wwd_tick #(
    .CYCLES (TICK_N)
  ) u_tick (
    .CLK   (CLK),
    .NRST  (NRST),
    .CLEAR (tick_clr),
    .TICK  (tick)
  );

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // never drives high, pull-up supplies the released level
  assign FAULT_RESET_OUTPUT_O    = 1'b0;
  assign FAULT_RESET_OUTPUT_OE_N = (s.fsm != ST_FAULT);
  assign IRQ       = |(s.status & s.mask);
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = s.rdata;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  a_init_kick_ignored: assert property (
    (s.fsm == ST_INIT) && !dis && (s.cnt < delay_ms) |=> (s.fsm == ST_INIT)
  ) else $error("kick or timer left power-up delay early");

  a_fault_kick_ignored: assert property (
    (s.fsm == ST_FAULT) && !dis && (s.cnt < delay_ms) |=> !FAULT_RESET_OUTPUT_OE_N
  ) else $error("fault output released before delay ended");

  a_off_kick_ignored: assert property (
    (s.fsm == ST_OFF) && dis |=> (s.fsm == ST_OFF) && (s.status[EV_GOOD] == 1'b0
      || $past(s.status[EV_GOOD]))
  ) else $error("disabled watchdog reacted to kick");

  a_timeout_asserts: assert property (
    (s.fsm == ST_WINDOW) && !dis && !fall && (s.cnt >= upper_ms)
      |=> !FAULT_RESET_OUTPUT_OE_N && s.status[EV_TIMEOUT] && (s.cnt == 16'h0000)
  ) else $error("missed window did not assert fault");

  a_off_released: assert property (
    dis ##1 dis |-> FAULT_RESET_OUTPUT_OE_N
  ) else $error("fault output low while disabled");

  a_open_drain_low: assert property (
    (FAULT_RESET_OUTPUT_O == 1'b0) && (FAULT_RESET_OUTPUT_OE_N == (s.fsm != ST_FAULT))
  ) else $error("fault pin driven other than low");

  a_select_disables: assert property (
    $rose(dis) |=> (s.fsm == ST_OFF)
  ) else $error("select code did not disable");

  a_upper_preset: assert property (
    (TIMEOUT_CONFIG_PIN == CFG_PULLUP) |-> (upper_ms == UP_PU_MS)
  ) else $error("pulled-up timeout pin not preset");

  a_lower_cap: assert property (
    (TIMEOUT_CONFIG_PIN == CFG_CAP) && (sel == SEL_RATIO4)
      |-> (lower_ms == {2'b00, s.cap_upper[15:2]})
  ) else $error("lower bound not select-derived in cap mode");

  a_delay_cap: assert property (
    (DELAY_CONFIG_PIN == CFG_CAP) |-> (delay_ms == s.cap_delay)
  ) else $error("capacitor delay not used");

  a_release_restart: assert property (
    (s.fsm == ST_FAULT) && !dis && (s.cnt >= delay_ms)
      |=> (s.fsm == ST_CLOSED) && (s.cnt == 16'h0000) && FAULT_RESET_OUTPUT_OE_N
  ) else $error("window timing not restarted after release");

  a_early_kick_fault: assert property (
    (s.fsm == ST_CLOSED) && !dis && fall
      |=> !FAULT_RESET_OUTPUT_OE_N && s.status[EV_EARLY]
  ) else $error("early kick did not assert fault");

  a_good_kick_restart: assert property (
    (s.fsm == ST_WINDOW) && !dis && fall
      |=> (s.fsm == ST_CLOSED) && (s.cnt == 16'h0000) && FAULT_RESET_OUTPUT_OE_N
  ) else $error("kick in window did not restart the period");

  a_window_keeps_count: assert property (
    (s.fsm == ST_CLOSED) && !dis && !fall && (s.cnt >= lower_ms)
      |=> (s.fsm == ST_WINDOW) && (s.cnt >= $past(s.cnt))
  ) else $error("period count lost at window opening");

  c_timeout:  cover property ((s.fsm == ST_WINDOW) ##1 (s.fsm == ST_FAULT));
  c_good:     cover property ((s.fsm == ST_WINDOW) && fall ##1 (s.fsm == ST_CLOSED));
  c_early:    cover property ((s.fsm == ST_CLOSED) && fall ##1 (s.fsm == ST_FAULT));
  c_released: cover property ((s.fsm == ST_FAULT) ##1 (s.fsm == ST_CLOSED));
  c_disabled: cover property ($rose(dis) ##1 (s.fsm == ST_OFF));

endmodule

// ### dv/wwd_kick_src.sv
// processor-side kick source for the window watchdog
`timescale 1ns/10ps
module wwd_kick_src (
  input  wire logic       CLK,
  input  wire logic       GO,
  input  wire logic [3:0] HOLD,
  output logic            KICK,
  output logic            BUSY
);
  logic [3:0] left;

  initial begin
    KICK = 1'b0;
    BUSY = 1'b0;
    left = 4'h0;
  end

  // line is always driven to a solid level, never left floating
  always @(posedge CLK) begin
    if (GO && !BUSY) begin
      KICK <= 1'b1;
      BUSY <= 1'b1;
      left <= HOLD;
    end else if (BUSY && left != 4'h0) begin
      left <= left - 4'h1;
    end else if (BUSY) begin
      KICK <= 1'b0; // one falling edge per request
      BUSY <= 1'b0;
    end
  end
endmodule

// ### dv/tb_top.sv
// self-checking testbench of the window watchdog
`timescale 1ns/10ps
module tb_top;
  import wwd_pkg::*;
  localparam int T = 10;
  logic        clk, nrst, kgo, hsel, hwrite;
  logic [3:0]  khold;
  logic [1:0]  sel, tcfg, dcfg, htrans;
  logic [31:0] haddr, hwdata, q;
  wire         kick_ln, kbusy, oe_n, fo, irq, hrdy, hresp;
  wire  [31:0] hrdata;
  wire         fault_wire = oe_n ? 1'b1 : fo;
  int          cyc, t0, compares, miscompares;
  // sel, timeout pin, delay pin, lower, upper, delay (ms), kick hold
  int rows [4][7] = '{'{2, 1, 1, 4, 8, 3, 0}, '{3, 2, 2, 4, 16, 5, 3},
                      '{0, 2, 0, 2, 16, 2, 0}, '{3, 0, 3, 3, 12, 5, 1}};

  wwd_top #(.TICK_N(T), .UP_PU_MS(16'h0008), .UP_NC_MS(16'h0010),
            .DLY_PU_MS(16'h0003), .DLY_NC_MS(16'h0005)) i_wwd_top (
    .CLK(clk), .NRST(nrst), .KICK_INPUT(kick_ln),
    .WINDOW_SELECT_BIT0(sel[0]), .WINDOW_SELECT_BIT1(sel[1]),
    .TIMEOUT_CONFIG_PIN(tcfg), .DELAY_CONFIG_PIN(dcfg),
    .FAULT_RESET_OUTPUT_I(fault_wire), .FAULT_RESET_OUTPUT_O(fo),
    .FAULT_RESET_OUTPUT_OE_N(oe_n), .IRQ(irq), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hrdy), .HREADYOUT(hrdy), .HRDATA(hrdata), .HRESP(hresp));

  wwd_kick_src i_wwd_kick_src (.CLK(clk), .GO(kgo), .HOLD(khold), .KICK(kick_ln),
                               .BUSY(kbusy));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  // ----------------------------------------------------------------------
  // checks and bus tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkr(input string n, input int lo, input int hi, input int g);
    compares++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("BAD %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask

  // hreadyout is the bus ready, so each phase waits on it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic kick(input logic [3:0] h);
    @(posedge clk);
    kgo   <= 1'b1;
    khold <= h;
    @(posedge clk);
    kgo <= 1'b0;
    do @(posedge clk); while (kbusy === 1'b1);
  endtask

  task automatic wait_fsm(input logic [4:0] f);
    int n;
    n = 0;
    do begin
      xfer(1'b0, OFS_STATE, 32'h0);
      n++;
    end while (q[12:8] !== f && n < 300);
    chk("fsm", {27'h0, f}, {27'h0, q[12:8]});
  endtask

  task automatic wait_oe(input logic v);
    int n;
    n = 0;
    while (oe_n !== v && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk("oe_n", {31'h0, v}, {31'h0, oe_n});
  endtask

  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  initial begin
    {nrst, kgo, khold, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {sel, tcfg, dcfg} = {2'h2, 2'h1, 2'h1};
    {compares, miscompares} = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    kick(4'h0);
    xfer(1'b0, OFS_STATE, 32'h0);
    chk("init", 32'h0104, q);
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk("status0", 32'h0, q);
    xfer(1'b0, OFS_MASK, 32'h0);
    chk("mask", {28'h0, MASK_RST}, q);
    xfer(1'b0, OFS_CAP_UPPER, 32'h0);
    chk("cap_upper", {16'h0, CAP_UPPER_RST}, q);
    xfer(1'b0, OFS_CAP_DELAY, 32'h0);
    chk("cap_delay", {16'h0, CAP_DELAY_RST}, q);
    xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, q);
    xfer(1'b1, OFS_CAP_UPPER, 32'hc);
    xfer(1'b1, OFS_CAP_DELAY, 32'h2);
    for (int r = 0; r < 4; r++) begin
      sel <= 2'h1;
      kick(4'h0);
      xfer(1'b0, OFS_STATE, 32'h0);
      chk("off", 32'h1006, q);
      xfer(1'b0, OFS_COUNT, 32'h0);
      chk("count_off", 32'h0, q);
      if (r == 1) xfer(1'b1, OFS_MASK, 32'h1);
      sel  <= 2'(rows[r][0]);
      tcfg <= 2'(rows[r][1]);
      dcfg <= 2'(rows[r][2]);
      xfer(1'b0, OFS_STATUS, 32'h0);
      wait_fsm(ST_WINDOW);
      kick(4'(rows[r][6]));
      t0 = cyc;
      wait_fsm(ST_WINDOW);
      chkr("lower", rows[r][3] * T, rows[r][3] * T + 7, cyc - t0);
      wait_oe(1'b0);
      chkr("upper", rows[r][4] * T - 2, rows[r][4] * T + 5, cyc - t0);
      t0 = cyc;
      chk("irq", {31'h0, r > 0}, {31'h0, irq});
      xfer(1'b0, OFS_STATE, 32'h0);
      chk("fault", 32'h0801, q);
      chk("pin_out", 32'h0, {31'h0, fo});
      kick(4'h0);
      wait_oe(1'b1);
      chkr("delay", rows[r][5] * T - 2, rows[r][5] * T + 4, cyc - t0);
      xfer(1'b0, OFS_STATE, 32'h0);
      chk("closed", 32'h0204, q);
      xfer(1'b0, OFS_STATUS, 32'h0);
      chk("status", 32'hd, q);
      repeat (2) @(posedge clk);
      chk("irq_clear", 32'h0, {31'h0, irq});
      kick(4'h0);
      repeat (2) @(posedge clk);
      chk("early", 32'h0, {31'h0, oe_n});
    end
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk("status_early", 32'h2, q);
    print_verdict();
  end

  // run takes about a thousand cycles; far beyond that means a hang
  initial begin
    #400000;
    miscompares++;
    print_verdict();
  end
endmodule
